// >>> pdm_defines.vh
`ifndef PDM_DEFINES_VH
`define PDM_DEFINES_VH

// ----------------------------------------
// Timing
// ----------------------------------------
`define PDM_CLK_PERIOD_PS 8000
`define PDM_SPIKE_NS 50
// Least time rounds up to whole cycles
`define PDM_SPIKE_CYCLES ((`PDM_SPIKE_NS * 1000 + `PDM_CLK_PERIOD_PS - 1) / `PDM_CLK_PERIOD_PS)
`define PDM_SPIKE_CW 4

// ----------------------------------------
// Port D bit positions
// ----------------------------------------
`define PDM_BIT_SCL 0
`define PDM_BIT_SDA 1
`define PDM_BIT_RX 2
`define PDM_BIT_TX 3
`define PDM_BIT_CAPT_A 4
`define PDM_BIT_XCK 5
`define PDM_BIT_CNT_A 6
`define PDM_BIT_CNT_BYTE 7
`define PDM_NUM_IRQ 4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PDM_PINS_RST 8'h00
`define PDM_IRQ_RST 4'h0
`define PDM_BIT_RST 1'h0
`define PDM_LINE_IDLE 1'h1

`endif

// >>> pdm_sync.v
`timescale 1ns/100ps

// ----------------------------------------
// Three-stage pin synchroniser
// ----------------------------------------
module pdm_sync #(
  parameter WIDTH = 8
) (
  input wire clk,
  input wire rst,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] level_q
);

  reg [WIDTH-1:0] s1_q;
  reg [WIDTH-1:0] s2_q;
  reg [WIDTH-1:0] s3_q;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          s1_q[i] <= 1'h0;
          s2_q[i] <= 1'h0;
          s3_q[i] <= 1'h0;
          level_q[i] <= 1'h0;
        end else begin
          s1_q[i] <= async_in[i];
          s2_q[i] <= s1_q[i];
          s3_q[i] <= s2_q[i];
          // A change counts only once the last two stages agree
          if (s2_q[i] == s3_q[i]) begin
            level_q[i] <= s3_q[i];
          end
        end
      end
    end
  endgenerate

endmodule // pdm_sync

// >>> pdm_spike.v
`timescale 1ns/100ps
`include "pdm_defines.vh"

// ----------------------------------------
// Spike filter for a two-wire bus line
// ----------------------------------------
module pdm_spike #(
  parameter CYCLES = `PDM_SPIKE_CYCLES
) (
  input wire clk,
  input wire rst,
  input wire level_in,
  output reg level_q
);

  reg [`PDM_SPIKE_CW-1:0] cnt_q;
  reg [`PDM_SPIKE_CW-1:0] cnt_d;

  always @* begin
    cnt_d = {`PDM_SPIKE_CW{1'b0}};
    if (level_in != level_q) begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  // Idle bus is high, so the filter starts there
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= {`PDM_SPIKE_CW{1'b0}};
      level_q <= `PDM_LINE_IDLE;
    end else if (level_in != level_q && cnt_d >= CYCLES[`PDM_SPIKE_CW-1:0]) begin
      cnt_q <= {`PDM_SPIKE_CW{1'b0}};
      level_q <= level_in;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule // pdm_spike

// >>> pdm_mux.v
`timescale 1ns/100ps
`include "pdm_defines.vh"

// Operation
// - Sync clock pin drives clock out when its direction bit set, else takes clock in.
// - Sync clock pin function only in synchronous mode; otherwise plain pin.
// - Transmitter enabled forces tx pin output with transmit data, pull-up off.
// - Receiver enabled forces rx pin input and routes its level to receiver.
// - Forced rx input still gets pull-up from port out bit unless globally disabled.
// - Two-wire enable detaches bit 1, making it the bidirectional data line.
// - Two-wire enable detaches bit 0, making it the bidirectional clock line.
// - Two-wire pin inputs reject pulses shorter than 50 ns.
// - Two-wire pins open drain: value low, direction from line-out, pull-up from out bit.
// - Bit 4 feeds first timer capture input, no overrides.
// - Bit 6 feeds first timer count input, no overrides.
// - Bits 0..3 feed interrupt sources; enabled interrupt forces input buffer on.
// - Clock-out fuse makes port E bit 7 drive divided clock, overriding registers.
// - With clock-out fuse, divided clock keeps driving during reset.
// - Port E bit 7 feeds second timer capture and interrupt source 7.
// - Variants without port E programming pins use MISO/MOSI for programming data.
// - Bit 7 feeds byte timer count input, no overrides.
module pdm_mux #(
  parameter PROG_ON_PORT_E = 0,
  parameter SPIKE_CYCLES = `PDM_SPIKE_CYCLES
) (
  input wire CLK,
  input wire SYS_RST,
  input wire [7:0] PD_OUT_BITS,
  input wire [7:0] PD_DIR_BITS,
  input wire PE7_OUT_BIT,
  input wire PE7_DIR_BIT,
  input wire GLOBAL_PULLUP_DISABLE,
  input wire SLEEP_INPUT_DISABLE,
  input wire SERIAL1_SYNC_MODE,
  input wire SERIAL1_SYNC_CLOCK_OUT,
  input wire SERIAL1_TX_ENABLE,
  input wire SERIAL1_TRANSMIT_LINE,
  input wire SERIAL1_RX_ENABLE,
  input wire TWO_WIRE_ENABLE,
  input wire TWO_WIRE_SDA_OUT,
  input wire TWO_WIRE_SCL_OUT,
  input wire [3:0] EXT_IRQ_ENABLE,
  input wire EXT_IRQ7_ENABLE,
  input wire CLOCK_OUT_FUSE,
  input wire DIVIDED_SYSCLK,
  input wire PROG_MODE,
  input wire PROG_DATA_OUT,
  input wire SPI_MOSI_LEVEL,
  input wire PE0_LEVEL,
  input wire [7:0] PD_PIN_I,
  input wire PE7_PIN_I,
  output reg [7:0] PD_PIN_O,
  output reg [7:0] PD_PIN_OE,
  output reg [7:0] PD_PULLUP_EN,
  output wire PE7_PIN_O,
  output wire PE7_PIN_OE,
  output reg PE7_PULLUP_EN,
  output reg [7:0] PD_PIN_LEVEL,
  output reg PE7_PIN_LEVEL,
  output reg SERIAL1_SYNC_CLOCK_IN,
  output reg SERIAL1_RECEIVE_LINE,
  output reg TWO_WIRE_SDA_IN,
  output reg TWO_WIRE_SCL_IN,
  output reg TIMER_A_CAPTURE_IN,
  output reg TIMER_A_COUNT_IN,
  output reg BYTE_TIMER_COUNT_IN,
  output reg [3:0] EXT_IRQ_SOURCE,
  output reg EXT_IRQ_SOURCE_7,
  output reg TIMER_B_CAPTURE_IN,
  output reg PROG_DATA_IN,
  output reg PROG_MISO_O,
  output reg PROG_MISO_OE,
  output reg PROG_PE1_O,
  output reg PROG_PE1_OE
);

  // ----------------------------------------
  // Input synchronisers and spike filters
  // ----------------------------------------
  wire [7:0] pd_level;
  wire pe7_level;
  wire sda_filt;
  wire scl_filt;

  pdm_sync #(
    .WIDTH(8)
  ) u_sync_pd (
    .clk(CLK),
    .rst(SYS_RST),
    .async_in(PD_PIN_I),
    .level_q(pd_level)
  );

  pdm_sync #(
    .WIDTH(1)
  ) u_sync_pe7 (
    .clk(CLK),
    .rst(SYS_RST),
    .async_in(PE7_PIN_I),
    .level_q(pe7_level)
  );

  // Filters sit after the synchroniser, so they never see a metastable stage
  pdm_spike #(
    .CYCLES(SPIKE_CYCLES)
  ) u_spike_sda (
    .clk(CLK),
    .rst(SYS_RST),
    .level_in(pd_level[`PDM_BIT_SDA]),
    .level_q(sda_filt)
  );

  pdm_spike #(
    .CYCLES(SPIKE_CYCLES)
  ) u_spike_scl (
    .clk(CLK),
    .rst(SYS_RST),
    .level_in(pd_level[`PDM_BIT_SCL]),
    .level_q(scl_filt)
  );

  // ----------------------------------------
  // Override sources per port D pin
  // ----------------------------------------
  reg [7:0] pu_ovr_en;
  reg [7:0] pu_ovr_val;
  reg [7:0] dir_ovr_en;
  reg [7:0] dir_ovr_val;
  reg [7:0] out_ovr_en;
  reg [7:0] out_ovr_val;
  reg [7:0] die_ovr_en;
  reg [7:0] die_ovr_val;
  wire xck_drive;

  assign xck_drive = SERIAL1_SYNC_MODE & PD_DIR_BITS[`PDM_BIT_XCK];

  always @* begin
    // Bits 4, 6 and 7 only listen, so they keep every default
    pu_ovr_en = `PDM_PINS_RST;
    pu_ovr_val = `PDM_PINS_RST;
    dir_ovr_en = `PDM_PINS_RST;
    dir_ovr_val = `PDM_PINS_RST;
    out_ovr_en = `PDM_PINS_RST;
    out_ovr_val = `PDM_PINS_RST;
    die_ovr_en = `PDM_PINS_RST;
    die_ovr_val = `PDM_PINS_RST;

    dir_ovr_en[`PDM_BIT_XCK] = xck_drive;
    dir_ovr_val[`PDM_BIT_XCK] = 1'b1;
    out_ovr_en[`PDM_BIT_XCK] = xck_drive;
    out_ovr_val[`PDM_BIT_XCK] = SERIAL1_SYNC_CLOCK_OUT;

    pu_ovr_en[`PDM_BIT_TX] = SERIAL1_TX_ENABLE;
    pu_ovr_val[`PDM_BIT_TX] = 1'b0;
    dir_ovr_en[`PDM_BIT_TX] = SERIAL1_TX_ENABLE;
    dir_ovr_val[`PDM_BIT_TX] = 1'b1;
    out_ovr_en[`PDM_BIT_TX] = SERIAL1_TX_ENABLE;
    out_ovr_val[`PDM_BIT_TX] = SERIAL1_TRANSMIT_LINE;

    pu_ovr_en[`PDM_BIT_RX] = SERIAL1_RX_ENABLE;
    pu_ovr_val[`PDM_BIT_RX] = PD_OUT_BITS[`PDM_BIT_RX] & ~GLOBAL_PULLUP_DISABLE;
    dir_ovr_en[`PDM_BIT_RX] = SERIAL1_RX_ENABLE;
    dir_ovr_val[`PDM_BIT_RX] = 1'b0;

    // Open drain: the bus line drives low only, the line-out picks direction
    pu_ovr_en[`PDM_BIT_SDA] = TWO_WIRE_ENABLE;
    pu_ovr_val[`PDM_BIT_SDA] = PD_OUT_BITS[`PDM_BIT_SDA] & ~GLOBAL_PULLUP_DISABLE;
    dir_ovr_en[`PDM_BIT_SDA] = TWO_WIRE_ENABLE;
    dir_ovr_val[`PDM_BIT_SDA] = TWO_WIRE_SDA_OUT;
    out_ovr_en[`PDM_BIT_SDA] = TWO_WIRE_ENABLE;
    out_ovr_val[`PDM_BIT_SDA] = 1'b0;

    pu_ovr_en[`PDM_BIT_SCL] = TWO_WIRE_ENABLE;
    pu_ovr_val[`PDM_BIT_SCL] = PD_OUT_BITS[`PDM_BIT_SCL] & ~GLOBAL_PULLUP_DISABLE;
    dir_ovr_en[`PDM_BIT_SCL] = TWO_WIRE_ENABLE;
    dir_ovr_val[`PDM_BIT_SCL] = TWO_WIRE_SCL_OUT;
    out_ovr_en[`PDM_BIT_SCL] = TWO_WIRE_ENABLE;
    out_ovr_val[`PDM_BIT_SCL] = 1'b0;

    // Enabled interrupts keep the input buffer alive even in sleep
    die_ovr_en[`PDM_NUM_IRQ-1:0] = EXT_IRQ_ENABLE;
    die_ovr_val[`PDM_NUM_IRQ-1:0] = {`PDM_NUM_IRQ{1'b1}};
  end

  // ----------------------------------------
  // Per-pin override merge
  // ----------------------------------------
  reg [7:0] pd_o_d;
  reg [7:0] pd_oe_d;
  reg [7:0] pd_pu_d;
  reg [7:0] pd_die;
  reg [7:0] pd_lvl_d;

  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_pin
      always @* begin
        pd_oe_d[i] = dir_ovr_en[i] ? dir_ovr_val[i] : PD_DIR_BITS[i];
        pd_o_d[i] = out_ovr_en[i] ? out_ovr_val[i] : PD_OUT_BITS[i];
        pd_pu_d[i] = pu_ovr_en[i] ? pu_ovr_val[i]
          : (PD_OUT_BITS[i] & ~PD_DIR_BITS[i] & ~GLOBAL_PULLUP_DISABLE);
        pd_die[i] = die_ovr_en[i] ? die_ovr_val[i] : ~SLEEP_INPUT_DISABLE;
        pd_lvl_d[i] = pd_level[i] & pd_die[i];
      end
    end
  endgenerate

  // ----------------------------------------
  // Port E bit 7
  // ----------------------------------------
  wire pe7_die;
  wire pe7_lvl_d;
  wire pe7_pu_d;
  reg pe7_o_q;
  reg pe7_oe_q;

  // Interrupt 7 keeps the buffer alive through sleep
  assign pe7_die = EXT_IRQ7_ENABLE | ~SLEEP_INPUT_DISABLE;
  assign pe7_lvl_d = pe7_level & pe7_die;
  // Pull-up stays off while the pin drives the clock, it would only load it
  assign pe7_pu_d = PE7_OUT_BIT & ~PE7_DIR_BIT & ~GLOBAL_PULLUP_DISABLE & ~CLOCK_OUT_FUSE;

  // The clock passes around the flops so that reset cannot silence it
  assign PE7_PIN_O = CLOCK_OUT_FUSE ? DIVIDED_SYSCLK : pe7_o_q;
  assign PE7_PIN_OE = CLOCK_OUT_FUSE | pe7_oe_q;

  // ----------------------------------------
  // Programming data placement
  // ----------------------------------------
  wire prog_on_e;
  wire prog_in_d;

  assign prog_on_e = (PROG_ON_PORT_E != 0);
  assign prog_in_d = prog_on_e ? PE0_LEVEL : SPI_MOSI_LEVEL;

  // ----------------------------------------
  // Port D pad controls
  // ----------------------------------------
  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      PD_PIN_O <= `PDM_PINS_RST;
      PD_PIN_OE <= `PDM_PINS_RST;
      PD_PULLUP_EN <= `PDM_PINS_RST;
      PD_PIN_LEVEL <= `PDM_PINS_RST;
    end else begin
      PD_PIN_O <= pd_o_d;
      PD_PIN_OE <= pd_oe_d;
      PD_PULLUP_EN <= pd_pu_d;
      PD_PIN_LEVEL <= pd_lvl_d;
    end
  end

  // ----------------------------------------
  // Port E bit 7 register path
  // ----------------------------------------
  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pe7_o_q <= `PDM_BIT_RST;
      pe7_oe_q <= `PDM_BIT_RST;
      PE7_PULLUP_EN <= `PDM_BIT_RST;
      PE7_PIN_LEVEL <= `PDM_BIT_RST;
    end else begin
      pe7_o_q <= PE7_OUT_BIT;
      pe7_oe_q <= PE7_DIR_BIT;
      PE7_PULLUP_EN <= pe7_pu_d;
      PE7_PIN_LEVEL <= pe7_lvl_d;
    end
  end

  // ----------------------------------------
  // Serial port inputs
  // ----------------------------------------
  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      SERIAL1_SYNC_CLOCK_IN <= `PDM_BIT_RST;
      SERIAL1_RECEIVE_LINE <= `PDM_LINE_IDLE;
    end else begin
      // Clock input only counts when the port is synchronous and a slave
      SERIAL1_SYNC_CLOCK_IN <= SERIAL1_SYNC_MODE & ~xck_drive
        & pd_lvl_d[`PDM_BIT_XCK];
      // Idle-high line while the receiver is off keeps it from framing noise
      SERIAL1_RECEIVE_LINE <= SERIAL1_RX_ENABLE
        ? pd_lvl_d[`PDM_BIT_RX] : `PDM_LINE_IDLE;
    end
  end

  // ----------------------------------------
  // Two-wire bus inputs
  // ----------------------------------------
  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      TWO_WIRE_SDA_IN <= `PDM_LINE_IDLE;
      TWO_WIRE_SCL_IN <= `PDM_LINE_IDLE;
    end else begin
      // Bus logic sees an idle bus while the pins belong to the port
      TWO_WIRE_SDA_IN <= TWO_WIRE_ENABLE ? sda_filt : `PDM_LINE_IDLE;
      TWO_WIRE_SCL_IN <= TWO_WIRE_ENABLE ? scl_filt : `PDM_LINE_IDLE;
    end
  end

  // ----------------------------------------
  // Timer and interrupt inputs
  // ----------------------------------------
  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      TIMER_A_CAPTURE_IN <= `PDM_BIT_RST;
      TIMER_A_COUNT_IN <= `PDM_BIT_RST;
      BYTE_TIMER_COUNT_IN <= `PDM_BIT_RST;
      EXT_IRQ_SOURCE <= `PDM_IRQ_RST;
      EXT_IRQ_SOURCE_7 <= `PDM_BIT_RST;
      TIMER_B_CAPTURE_IN <= `PDM_BIT_RST;
    end else begin
      TIMER_A_CAPTURE_IN <= pd_lvl_d[`PDM_BIT_CAPT_A];
      TIMER_A_COUNT_IN <= pd_lvl_d[`PDM_BIT_CNT_A];
      BYTE_TIMER_COUNT_IN <= pd_lvl_d[`PDM_BIT_CNT_BYTE];
      EXT_IRQ_SOURCE <= pd_lvl_d[`PDM_NUM_IRQ-1:0];
      EXT_IRQ_SOURCE_7 <= pe7_lvl_d;
      TIMER_B_CAPTURE_IN <= pe7_lvl_d;
    end
  end

  // ----------------------------------------
  // Programming data
  // ----------------------------------------
  // Only one placement exists per variant, so the other pair's enable stays low while its data still follows
  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      PROG_DATA_IN <= `PDM_BIT_RST;
      PROG_MISO_O <= `PDM_BIT_RST;
      PROG_MISO_OE <= `PDM_BIT_RST;
      PROG_PE1_O <= `PDM_BIT_RST;
      PROG_PE1_OE <= `PDM_BIT_RST;
    end else begin
      PROG_DATA_IN <= PROG_MODE & prog_in_d;
      PROG_MISO_O <= PROG_DATA_OUT;
      PROG_MISO_OE <= PROG_MODE & ~prog_on_e;
      PROG_PE1_O <= PROG_DATA_OUT;
      PROG_PE1_OE <= PROG_MODE & prog_on_e;
    end
  end

endmodule // pdm_mux

// >>> pdm_mux_monitor.sv
`timescale 1ns/100ps

// ----------------------------------------
// Override and input path checker
// ----------------------------------------
module pdm_mon (
  input wire CLK,
  input wire SYS_RST,
  input wire [7:0] PD_OUT_BITS,
  input wire [7:0] PD_DIR_BITS,
  input wire GLOBAL_PULLUP_DISABLE,
  input wire SLEEP_INPUT_DISABLE,
  input wire SERIAL1_SYNC_MODE,
  input wire SERIAL1_SYNC_CLOCK_OUT,
  input wire SERIAL1_TX_ENABLE,
  input wire SERIAL1_TRANSMIT_LINE,
  input wire SERIAL1_RX_ENABLE,
  input wire TWO_WIRE_ENABLE,
  input wire TWO_WIRE_SDA_OUT,
  input wire TWO_WIRE_SCL_OUT,
  input wire [3:0] EXT_IRQ_ENABLE,
  input wire CLOCK_OUT_FUSE,
  input wire DIVIDED_SYSCLK,
  input wire [7:0] PD_PIN_I,
  input wire [7:0] PD_PIN_O,
  input wire [7:0] PD_PIN_OE,
  input wire [7:0] PD_PULLUP_EN,
  input wire PE7_PIN_O,
  input wire PE7_PIN_OE,
  input wire [7:0] PD_PIN_LEVEL,
  input wire TIMER_A_CAPTURE_IN
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  // Seven samples cover sync chain, accept stage and output register
  sequence s_pad4_high;
    (PD_PIN_I[4] && !SLEEP_INPUT_DISABLE)[*7];
  endsequence
  sequence s_pin3_gated;
    (SLEEP_INPUT_DISABLE && !EXT_IRQ_ENABLE[3])[*3];
  endsequence

  property p_tx;
    SERIAL1_TX_ENABLE |=> PD_PIN_OE[3] && !PD_PULLUP_EN[3]
      && PD_PIN_O[3] == $past(SERIAL1_TRANSMIT_LINE);
  endproperty
  a_tx: assert property (p_tx) else $error("tx pin override wrong");
  property p_rx;
    SERIAL1_RX_ENABLE |=> !PD_PIN_OE[2]
      && PD_PULLUP_EN[2] == ($past(PD_OUT_BITS[2]) && !$past(GLOBAL_PULLUP_DISABLE));
  endproperty
  a_rx: assert property (p_rx) else $error("rx pin override wrong");
  property p_twi;
    TWO_WIRE_ENABLE |=> PD_PIN_O[1:0] == 2'h0
      && PD_PIN_OE[1:0] == {$past(TWO_WIRE_SDA_OUT), $past(TWO_WIRE_SCL_OUT)};
  endproperty
  a_twi: assert property (p_twi) else $error("two-wire drive wrong");
  property p_xck;
    SERIAL1_SYNC_MODE && PD_DIR_BITS[5] |=> PD_PIN_OE[5]
      && PD_PIN_O[5] == $past(SERIAL1_SYNC_CLOCK_OUT);
  endproperty
  a_xck: assert property (p_xck) else $error("sync clock out wrong");
  property p_plain4;
    !SYS_RST |=> PD_PIN_OE[4] == $past(PD_DIR_BITS[4]) && PD_PIN_O[4] == $past(PD_OUT_BITS[4])
      && PD_PULLUP_EN[4] == ($past(PD_OUT_BITS[4]) && !$past(PD_DIR_BITS[4])
      && !$past(GLOBAL_PULLUP_DISABLE));
  endproperty
  a_plain4: assert property (p_plain4) else $error("pin 4 overridden");
  property p_fuse;
    CLOCK_OUT_FUSE |-> PE7_PIN_OE && PE7_PIN_O == DIVIDED_SYSCLK;
  endproperty
  a_fuse: assert property (p_fuse) else $error("clock out missing");
  property p_capt;
    s_pad4_high |-> TIMER_A_CAPTURE_IN;
  endproperty
  a_capt: assert property (p_capt) else $error("capture input stale");
  property p_gate;
    s_pin3_gated |-> !PD_PIN_LEVEL[3];
  endproperty
  a_gate: assert property (p_gate) else $error("input buffer not off");
endmodule // pdm_mon

bind pdm_mux pdm_mon u_mon (.CLK, .SYS_RST, .PD_OUT_BITS, .PD_DIR_BITS,
  .GLOBAL_PULLUP_DISABLE, .SLEEP_INPUT_DISABLE, .SERIAL1_SYNC_MODE,
  .SERIAL1_SYNC_CLOCK_OUT, .SERIAL1_TX_ENABLE, .SERIAL1_TRANSMIT_LINE, .SERIAL1_RX_ENABLE,
  .TWO_WIRE_ENABLE, .TWO_WIRE_SDA_OUT, .TWO_WIRE_SCL_OUT, .EXT_IRQ_ENABLE,
  .CLOCK_OUT_FUSE, .DIVIDED_SYSCLK, .PD_PIN_I, .PD_PIN_O, .PD_PIN_OE, .PD_PULLUP_EN,
  .PE7_PIN_O, .PE7_PIN_OE, .PD_PIN_LEVEL, .TIMER_A_CAPTURE_IN);

// >>> pdm_board.sv
`timescale 1ns/100ps

// ----------------------------------------
// Pad and board model
// ----------------------------------------
module pdm_board (
  input wire clk,
  input wire [8:0] pin_o,
  input wire [8:0] pin_oe,
  input wire [8:0] pull_en,
  input wire [8:0] ext_en,
  input wire [8:0] ext_v,
  output wire [8:0] pin_i
);
  reg float_q = 1'h0;
  // Undriven pads wander so a stale level is never trusted
  always @(posedge clk) begin
    float_q <= ~float_q;
  end
  // Own driver wins, then board driver, then pull-up, else floating
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_en & ext_v)
    | (~pin_oe & ~ext_en & (pull_en | {9{float_q}}));
endmodule // pdm_board

// >>> pdm_mux_tb_top.sv
`timescale 1ns/100ps

module pdm_mux_tb_top;
  reg clk, rst, pe7_out, pe7_dir, gpd, sleep, smode, sclk, txe, txd, rxe;
  reg twe, sda_o, scl_o, irq7, fuse, dclk, pmode, prog_data_out, mosi, pe0;
  reg [7:0] pd_out, pd_dir;
  reg [3:0] irq_en;
  reg [8:0] ext_en, ext_v;
  wire [7:0] pd_o, pd_oe, pd_pu, pd_lvl;
  wire [3:0] irq;
  wire [8:0] pad;
  wire pe7_o, pe7_oe, pe7_pu, pe7_lvl, xck_in, rxd, sda_in, scl_in, cap_a, cnt_a, cnt_b;
  wire irq7s, cap_b, prog_data_in, miso_o, miso_oe, pe1_o, pe1_oe;
  integer n_fail, checked;

  // ----------------------------------------
  // Design and board
  // ----------------------------------------
  pdm_mux #(.PROG_ON_PORT_E(0), .SPIKE_CYCLES(3)) uut (
    .CLK(clk), .SYS_RST(rst), .PD_OUT_BITS(pd_out), .PD_DIR_BITS(pd_dir),
    .PE7_OUT_BIT(pe7_out), .PE7_DIR_BIT(pe7_dir), .GLOBAL_PULLUP_DISABLE(gpd),
    .SLEEP_INPUT_DISABLE(sleep), .SERIAL1_SYNC_MODE(smode), .SERIAL1_SYNC_CLOCK_OUT(sclk),
    .SERIAL1_TX_ENABLE(txe), .SERIAL1_TRANSMIT_LINE(txd), .SERIAL1_RX_ENABLE(rxe),
    .TWO_WIRE_ENABLE(twe), .TWO_WIRE_SDA_OUT(sda_o), .TWO_WIRE_SCL_OUT(scl_o),
    .EXT_IRQ_ENABLE(irq_en), .EXT_IRQ7_ENABLE(irq7), .CLOCK_OUT_FUSE(fuse),
    .DIVIDED_SYSCLK(dclk), .PROG_MODE(pmode), .PROG_DATA_OUT(prog_data_out), .SPI_MOSI_LEVEL(mosi),
    .PE0_LEVEL(pe0), .PD_PIN_I(pad[7:0]), .PE7_PIN_I(pad[8]), .PD_PIN_O(pd_o),
    .PD_PIN_OE(pd_oe), .PD_PULLUP_EN(pd_pu), .PE7_PIN_O(pe7_o), .PE7_PIN_OE(pe7_oe),
    .PE7_PULLUP_EN(pe7_pu), .PD_PIN_LEVEL(pd_lvl), .PE7_PIN_LEVEL(pe7_lvl),
    .SERIAL1_SYNC_CLOCK_IN(xck_in), .SERIAL1_RECEIVE_LINE(rxd), .TWO_WIRE_SDA_IN(sda_in),
    .TWO_WIRE_SCL_IN(scl_in), .TIMER_A_CAPTURE_IN(cap_a), .TIMER_A_COUNT_IN(cnt_a),
    .BYTE_TIMER_COUNT_IN(cnt_b), .EXT_IRQ_SOURCE(irq), .EXT_IRQ_SOURCE_7(irq7s),
    .TIMER_B_CAPTURE_IN(cap_b), .PROG_DATA_IN(prog_data_in), .PROG_MISO_O(miso_o),
    .PROG_MISO_OE(miso_oe), .PROG_PE1_O(pe1_o), .PROG_PE1_OE(pe1_oe));
  pdm_board u_board (.clk(clk), .pin_o({pe7_o, pd_o}), .pin_oe({pe7_oe, pd_oe}),
    .pull_en({pe7_pu, pd_pu}), .ext_en(ext_en), .ext_v(ext_v), .pin_i(pad));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task ck(input [8:0] got, input [8:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Waits n rising edges chosen by the caller, then settles to mid-cycle
  task wt(input integer n);
    begin
      repeat (n) @(posedge clk);
      @(negedge clk);
    end
  endtask
  task test_done;
    begin
      if (n_fail == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask

  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    dclk <= ~dclk;
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    n_fail = 0;
    checked = 0;
    {rst, fuse, dclk} = 3'h6;
    {pe7_out, pe7_dir, gpd, sleep, smode, sclk, txe, txd, rxe} = 9'h000;
    {twe, sda_o, scl_o, irq7, pmode, prog_data_out, mosi, pe0} = 8'h00;
    {pd_out, pd_dir, irq_en} = 20'h00000;
    {ext_en, ext_v} = 18'h00000;
    wt(1);
    ck(pe7_oe, 1'h1);
    ck(pe7_o, dclk);
    ck(pd_oe, 8'h00);
    @(posedge clk);
    rst <= 1'h0;
    pd_out <= 8'hA5;
    pd_dir <= 8'h0F;
    wt(2);
    ck(pd_oe, 8'h0F);
    ck(pd_o, 8'hA5);
    ck(pd_pu, 8'hA0);
    ck(pe7_oe, 1'h1);
    ck(pe7_o, dclk);
    @(posedge clk);
    {txe, txd, rxe, smode, sclk, twe, sda_o, scl_o} <= 8'hFE;
    pd_dir <= 8'h27;
    wt(2);
    ck(pd_oe, 8'h2A);
    ck(pd_o, 8'hAC);
    ck(pd_pu, 8'h85);
    @(posedge clk);
    gpd <= 1'h1;
    fuse <= 1'h0;
    ext_en <= 9'h1D5;
    ext_v <= 9'h1D0;
    wt(12);
    ck(pd_pu, 8'h00);
    ck(rxd, 1'h0);
    ck({cap_a, cnt_a, cnt_b, cap_b, irq7s}, 5'h1F);
    ck({sda_in, scl_in, xck_in}, 3'h0);
    ck(irq, 4'h8);
    @(posedge clk);
    pd_dir <= 8'h07;
    ext_en <= 9'h1F5;
    ext_v <= 9'h1F0;
    wt(8);
    ck({xck_in, pd_oe[5]}, 2'h2);
    @(posedge clk);
    smode <= 1'h0;
    wt(8);
    ck(xck_in, 1'h0);
    @(posedge clk);
    sda_o <= 1'h0;
    ext_en <= 9'h1F7;
    ext_v <= 9'h1F2;
    wt(12);
    ck(sda_in, 1'h1);
    // Two-cycle dip passes the synchroniser but is shorter than the filter window
    @(posedge clk);
    ext_v <= 9'h1F0;
    repeat (2) @(posedge clk);
    ext_v <= 9'h1F2;
    wt(12);
    ck(sda_in, 1'h1);
    @(posedge clk);
    ext_v <= 9'h1F0;
    wt(12);
    ck(sda_in, 1'h0);
    @(posedge clk);
    twe <= 1'h0;
    wt(8);
    ck({sda_in, pd_oe[1]}, 2'h3);
    @(posedge clk);
    {fuse, pe7_dir, pe7_out, pmode, mosi, prog_data_out} <= 6'h17;
    wt(4);
    ck({pe7_oe, pe7_o}, 2'h2);
    ck({prog_data_in, miso_o, miso_oe}, 3'h7);
    ck({pe1_o, pe1_oe}, 2'h2);
    @(posedge clk);
    {pe7_dir, sleep, irq7} <= 3'h3;
    pe7_out <= 1'h1;
    gpd <= 1'h0;
    irq_en <= 4'h1;
    wt(8);
    ck({pd_lvl[0], pd_lvl[4], pe7_lvl}, 3'h5);
    ck(irq[0], 1'h1);
    ck(pe7_pu, 1'h1);
    test_done;
  end
endmodule // pdm_mux_tb_top
